// file: pkg/balance_params.svh
/*
 holds timing counts, reset values and widths for the cell balancing block.
 assumes a 100 MHz clock; included by bare name from the rtl files.
*/
`ifndef BALANCE_PARAMS_SVH
`define BALANCE_PARAMS_SVH

`define CELL_COUNT 15
`define DUTY_WIDTH 4
`define DUTY_RESET 4'hF
`define CLOCK_PERIOD_NS 10
`define STAGGER_TIME_US 62500
`define STAGGER_CYCLES ((`STAGGER_TIME_US * 1000) / `CLOCK_PERIOD_NS)
`define SLOTS_PER_STEP 32
`define STEPS_PER_PERIOD 15
`define PERIOD_TIME_S 30

`endif

// file: pkg/balance_pkg.sv
/*
 holds the types shared by the balancing block files.
 assumes nothing of its surroundings.
*/
package balance_pkg;
    typedef enum logic [1:0] {
        mode_direct,
        mode_modulated,
        mode_sleep
    } balance_mode_e;

    typedef enum logic [1:0] {
        mon_idle,
        mon_wait,
        mon_check
    } monitor_state_e;
endpackage

// file: rtl/slow_timebase.sv
/*
 holds the free-running slow timebase: a 62.5 ms slot tick and a slot count.
 assumes a 100 MHz clock and a clock enable that freezes all state.
*/
`include "balance_params.svh"

module slow_timebase #(
    parameter int unsigned SLOT_CYCLES = `STAGGER_CYCLES,
    parameter int unsigned SLOTS_PER_PERIOD = `SLOTS_PER_STEP * `STEPS_PER_PERIOD
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic enable,
    output logic slot_tick,
    output logic [8:0] slot_count
);
    logic [22:0] div_reg;
    logic [22:0] div_next;
    logic [8:0] slot_reg;
    logic [8:0] slot_next;
    logic tick_reg;
    logic tick_next;

    // ************************************************
    // divider and slot counter
    // ************************************************
    always_comb begin
        div_next = div_reg;
        slot_next = slot_reg;
        tick_next = 1'b0;
        if (div_reg == 23'(SLOT_CYCLES - 1)) begin
            div_next = 23'h000000;
            tick_next = 1'b1;
            if (slot_reg == 9'(SLOTS_PER_PERIOD - 1)) begin
                slot_next = 9'h000;
            end else begin
                slot_next = slot_reg + 9'h001;
            end
        end else begin
            div_next = div_reg + 23'h000001;
        end
    end

    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            div_reg <= 23'h000000;
            slot_reg <= 9'h000;
            tick_reg <= 1'b0;
        end else if (enable) begin
            div_reg <= div_next;
            slot_reg <= slot_next;
            tick_reg <= tick_next;
        end
    end

    assign slot_tick = tick_reg;
    assign slot_count = slot_reg;

    slot_wrap_a: assert property (@(posedge clock) disable iff (!rst_b)
        slot_reg <= 9'(SLOTS_PER_PERIOD - 1))
        else $error("slot count beyond period");
endmodule // slow_timebase

// file: rtl/duty_compare.sv
/*
 holds the per-channel modulation decision for all cells.
 assumes a slot count from the shared timebase, 32 slots per 2 s step.
*/
`include "balance_params.svh"

module duty_compare #(
    parameter int unsigned CELLS = `CELL_COUNT
) (
    input wire logic [8:0] slot_count,
    input wire logic [CELLS*4-1:0] duty_flat,
    input wire logic [CELLS-1:0] enable_bits,
    output logic [CELLS-1:0] on_bits
);
    // channel c sees the period shifted by c slots, so edges never coincide
    function automatic logic chan_on(input logic [8:0] slot, input logic [3:0] duty,
                                     input int unsigned chan);
        logic [9:0] shifted;
        logic [9:0] wrapped;
        logic [4:0] step;
        shifted = {1'b0, slot} + 10'(chan);
        wrapped = (shifted >= 10'(`SLOTS_PER_STEP * `STEPS_PER_PERIOD)) ?
                  shifted - 10'(`SLOTS_PER_STEP * `STEPS_PER_PERIOD) : shifted;
        step = 5'(wrapped / 10'(`SLOTS_PER_STEP));
        if (duty == `DUTY_RESET) begin
            chan_on = 1'b1;
        end else begin
            chan_on = (step < {1'b0, duty});
        end
    endfunction

    always_comb begin
        for (int unsigned c = 0; c < CELLS; c++) begin
            on_bits[c] = enable_bits[c] && chan_on(slot_count, duty_flat[c*4 +: 4], c);
        end
    end
endmodule // duty_compare

// file: rtl/cell_discharge_pwm_monitor.sv
/*
 holds the discharge switch control: direct drive, modulated drive after the
 watchdog expires, and the discharge-timer cell monitor.
 assumes conversion results and timer events arrive as synchronous pulses.
*/
`include "balance_params.svh"

module cell_discharge_pwm_monitor #(
    parameter int unsigned CELLS = `CELL_COUNT,
    parameter int unsigned SLOT_CYCLES = `STAGGER_CYCLES
) (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic clock_enable,
    input wire logic write_config_group_one_cmd,
    input wire logic [CELLS-1:0] enable_write_data,
    input wire logic duty_write,
    input wire logic [CELLS*4-1:0] duty_write_data,
    input wire logic timer_monitor_enable,
    input wire logic watchdog_expired,
    input wire logic wakeup,
    input wire logic discharge_timeout,
    input wire logic conversion_done,
    input wire logic [CELLS-1:0] cell_over,
    input wire logic [CELLS-1:0] cell_under,
    input wire logic redundancy_fail,
    output logic [CELLS-1:0] discharge_switch,
    output logic [CELLS-1:0] cell_discharge_enable,
    output logic [CELLS*4-1:0] duty_setting,
    output logic [CELLS-1:0] over_flag,
    output logic [CELLS-1:0] under_flag,
    output logic conversion_start,
    output logic discharge_timer_restart,
    output logic modulating,
    output logic sleeping
);
    logic slot_tick;
    logic [8:0] slot_count;
    logic [CELLS-1:0] pwm_on;

    balance_pkg::balance_mode_e mode_reg;
    balance_pkg::balance_mode_e mode_next;
    balance_pkg::monitor_state_e mon_reg;
    balance_pkg::monitor_state_e mon_next;
    logic [CELLS-1:0] enable_reg;
    logic [CELLS-1:0] enable_next;
    logic [CELLS*4-1:0] duty_reg;
    logic [CELLS*4-1:0] duty_next;
    logic [CELLS-1:0] switch_reg;
    logic [CELLS-1:0] switch_next;
    logic [CELLS-1:0] over_reg;
    logic [CELLS-1:0] over_next;
    logic [CELLS-1:0] under_reg;
    logic [CELLS-1:0] under_next;
    logic start_reg;
    logic start_next;
    logic restart_reg;
    logic restart_next;
    logic modulating_reg;
    logic modulating_next;
    logic sleeping_reg;
    logic sleeping_next;

    // ************************************************
    // shared timebase and per-channel compare
    // ************************************************
    slow_timebase #(
        .SLOT_CYCLES(SLOT_CYCLES),
        .SLOTS_PER_PERIOD(`SLOTS_PER_STEP * `STEPS_PER_PERIOD)
    ) slow_timebase_inst (
        .clock(clock),
        .rst_b(rst_b),
        .enable(clock_enable),
        .slot_tick(slot_tick),
        .slot_count(slot_count)
    );

    duty_compare #(
        .CELLS(CELLS)
    ) duty_compare_inst (
        .slot_count(slot_count),
        .duty_flat(duty_reg),
        .enable_bits(enable_reg),
        .on_bits(pwm_on)
    );

    // ************************************************
    // mode, configuration and monitor
    // ************************************************
    always_comb begin
        mode_next = mode_reg;
        mon_next = mon_reg;
        enable_next = enable_reg;
        duty_next = duty_reg;
        over_next = over_reg;
        under_next = under_reg;
        start_next = 1'b0;
        restart_next = 1'b0;
        // host writes first, so monitor clears below win in the same cycle
        if (write_config_group_one_cmd) begin
            enable_next = enable_write_data;
            restart_next = 1'b1;
            if (mode_reg == balance_pkg::mode_sleep) begin
                mode_next = balance_pkg::mode_direct;
            end
        end
        if (duty_write) begin
            duty_next = duty_write_data;
        end
        unique case (mode_reg)
            balance_pkg::mode_direct: begin
                if (discharge_timeout) begin
                    enable_next = '0;
                    duty_next = {CELLS{`DUTY_RESET}};
                end else if (watchdog_expired) begin
                    mode_next = balance_pkg::mode_modulated;
                end
            end
            balance_pkg::mode_modulated: begin
                if (wakeup || !watchdog_expired) begin
                    mode_next = balance_pkg::mode_direct;
                end else if (discharge_timeout) begin
                    mode_next = balance_pkg::mode_sleep;
                    enable_next = '0;
                    duty_next = {CELLS{`DUTY_RESET}};
                end
            end
            balance_pkg::mode_sleep: begin
                duty_next = {CELLS{`DUTY_RESET}};
            end
            default: begin
                mode_next = balance_pkg::mode_direct;
            end
        endcase
        // one conversion per 30 s period, launched at the period wrap
        unique case (mon_reg)
            balance_pkg::mon_idle: begin
                if (mode_reg == balance_pkg::mode_modulated && timer_monitor_enable
                        && slot_tick && slot_count == 9'h000) begin
                    start_next = 1'b1;
                    mon_next = balance_pkg::mon_wait;
                end
            end
            balance_pkg::mon_wait: begin
                if (conversion_done) begin
                    mon_next = balance_pkg::mon_check;
                end else if (mode_reg != balance_pkg::mode_modulated) begin
                    mon_next = balance_pkg::mon_idle;
                end
            end
            balance_pkg::mon_check: begin
                over_next = cell_over;
                under_next = cell_under;
                enable_next = enable_next & ~cell_under;
                if (redundancy_fail) begin
                    enable_next = '0;
                end
                mon_next = balance_pkg::mon_idle;
            end
            default: begin
                mon_next = balance_pkg::mon_idle;
            end
        endcase
        // gate with the next enables: a monitor clear must open the switch at once
        if (mode_next == balance_pkg::mode_modulated) begin
            switch_next = pwm_on & enable_next;
        end else if (mode_next == balance_pkg::mode_direct) begin
            switch_next = enable_next;
        end else begin
            switch_next = '0;
        end
        // status outputs are registered copies of the next mode
        modulating_next = (mode_next == balance_pkg::mode_modulated);
        sleeping_next = (mode_next == balance_pkg::mode_sleep);
    end

    // ************************************************
    // registers
    // ************************************************
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= balance_pkg::mode_direct;
            mon_reg <= balance_pkg::mon_idle;
            enable_reg <= '0;
            duty_reg <= {CELLS{`DUTY_RESET}};
            switch_reg <= '0;
            over_reg <= '0;
            under_reg <= '0;
            start_reg <= 1'b0;
            restart_reg <= 1'b0;
            modulating_reg <= 1'b0;
            sleeping_reg <= 1'b0;
        end else if (clock_enable) begin
            mode_reg <= mode_next;
            mon_reg <= mon_next;
            enable_reg <= enable_next;
            duty_reg <= duty_next;
            switch_reg <= switch_next;
            over_reg <= over_next;
            under_reg <= under_next;
            start_reg <= start_next;
            restart_reg <= restart_next;
            modulating_reg <= modulating_next;
            sleeping_reg <= sleeping_next;
        end
    end

    assign discharge_switch = switch_reg;
    assign cell_discharge_enable = enable_reg;
    assign duty_setting = duty_reg;
    assign over_flag = over_reg;
    assign under_flag = under_reg;
    assign conversion_start = start_reg;
    assign discharge_timer_restart = restart_reg;
    assign modulating = modulating_reg;
    assign sleeping = sleeping_reg;

    // ************************************************
    // checks
    // ************************************************
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // marks the cells whose duty field holds one code
    function automatic logic [CELLS-1:0] code_mask(input logic [CELLS*4-1:0] duties,
                                                   input logic [3:0] code);
        for (int unsigned c = 0; c < CELLS; c++) begin
            code_mask[c] = (duties[c*4 +: 4] == code);
        end
    endfunction

    // a low clock enable holds every register, so checks look one enabled edge back
    direct_follow_a: assert property ($past(clock_enable)
        && mode_reg == balance_pkg::mode_direct && $stable(mode_reg)
        |-> switch_reg == $past(enable_next))
        else $error("direct output not following enable");
    gated_enable_a: assert property ((discharge_switch & ~cell_discharge_enable) == '0)
        else $error("output on with enable clear");
    expiry_mode_a: assert property (clock_enable
        && mode_reg == balance_pkg::mode_direct && watchdog_expired && !discharge_timeout
        |=> modulating)
        else $error("no modulation after expiry");
    timeout_sleep_a: assert property (clock_enable && discharge_timeout
        && mode_reg == balance_pkg::mode_modulated && watchdog_expired && !wakeup
        |=> sleeping && cell_discharge_enable == '0)
        else $error("no sleep after timeout");
    wake_direct_a: assert property (clock_enable
        && mode_reg == balance_pkg::mode_modulated && (wakeup || !watchdog_expired)
        |=> !modulating && !sleeping)
        else $error("modulation kept after wake-up");
    zero_off_a: assert property ($past(clock_enable) && modulating
        |-> (discharge_switch & code_mask($past(duty_reg), 4'h0)) == '0)
        else $error("zero duty output on");
    full_on_a: assert property ($past(clock_enable) && modulating
        |-> (code_mask($past(duty_reg), `DUTY_RESET) & $past(enable_reg) & $past(enable_next)
        & ~discharge_switch) == '0)
        else $error("full duty output off");
    sleep_duty_a: assert property (sleeping |=> duty_reg == {CELLS{`DUTY_RESET}})
        else $error("duty not default in sleep");
    under_clear_a: assert property (clock_enable && mon_reg == balance_pkg::mon_check
        |=> (cell_discharge_enable & $past(cell_under)) == '0)
        else $error("undervoltage enable not cleared");
    redund_clear_a: assert property (clock_enable && mon_reg == balance_pkg::mon_check
        && redundancy_fail |=> cell_discharge_enable == '0)
        else $error("redundancy failure left enables");
    flag_load_a: assert property (clock_enable && mon_reg == balance_pkg::mon_check
        |=> over_flag == $past(cell_over) && under_flag == $past(cell_under))
        else $error("flags not loaded");
    flag_hold_a: assert property ($past(mon_reg) != balance_pkg::mon_check
        |-> $stable(over_flag) && $stable(under_flag))
        else $error("flags moved outside check");
    restart_only_a: assert property (discharge_timer_restart
        |-> $past(write_config_group_one_cmd))
        else $error("timer restart without write");
    timeout_off_a: assert property (clock_enable
        && mode_reg == balance_pkg::mode_direct
        && discharge_timeout && !write_config_group_one_cmd
        |=> cell_discharge_enable == '0 && duty_reg == {CELLS{`DUTY_RESET}})
        else $error("timeout did not disable");
    conv_start_a: assert property (conversion_start
        |-> $past(timer_monitor_enable) && $past(modulating))
        else $error("conversion without monitor");

    cover_modulate_c: cover property (modulating ##1 discharge_switch != '0);
    cover_monitor_c: cover property (conversion_start ##[1:20] mon_reg == balance_pkg::mon_check);
    cover_sleep_c: cover property (modulating ##1 sleeping);
    cover_wake_c: cover property (modulating ##1 !modulating && !sleeping);
endmodule // cell_discharge_pwm_monitor

// file: bench/cell_converter_model.sv
/*
 holds a model of the cell converter behind the block: it answers each
 conversion request with a done pulse and threshold results.
 assumes the block samples results in the cycle after conversion_done.
*/
module cell_converter_model (
    input wire logic clock,
    input wire logic rst_b,
    input wire logic conversion_start,
    input wire logic [14:0] under_mask,
    input wire logic [14:0] over_mask,
    input wire logic fail_req,
    output logic conversion_done,
    output logic [14:0] cell_over,
    output logic [14:0] cell_under,
    output logic redundancy_fail
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // converter timing
    // ****************************************
    logic [2:0] delay_reg;
    logic valid_reg;
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            delay_reg <= 3'h0;
            conversion_done <= 1'h0;
            valid_reg <= 1'h0;
        end else begin
            conversion_done <= (delay_reg == 3'h1);
            valid_reg <= conversion_done;
            if (conversion_start) begin
                delay_reg <= 3'h4;
            end else if (delay_reg != 3'h0) begin
                delay_reg <= delay_reg - 3'h1;
            end
        end
    end
    // stale results show the inverse, so a late sample never matches
    assign cell_under = valid_reg ? under_mask : ~under_mask;
    assign cell_over = valid_reg ? over_mask : ~over_mask;
    assign redundancy_fail = valid_reg ? fail_req : ~fail_req;
endmodule // cell_converter_model

// file: bench/cell_discharge_pwm_monitor_tb.sv
/*
 holds the self-checking bench of the discharge switch control block.
 assumes the converter model file and a short slot length of 4 cycles.
*/
module cell_discharge_pwm_monitor_tb;
    timeunit 1ns;
    timeprecision 100ps;
    // ****************************************
    // set-up
    // ****************************************
    localparam int SLOT = 4;
    localparam int PER = 480 * SLOT;
    localparam int STEP = 32 * SLOT;
    logic clock = 1'h0;
    logic rst_b = 1'h0;
    logic clock_enable = 1'h1;
    logic wr_cmd = 1'h0;
    logic [14:0] en_data = 15'h0000;
    logic duty_write = 1'h0;
    logic [59:0] duty_data = 60'h0;
    logic mon_en = 1'h0;
    logic wdt_exp = 1'h0;
    logic wakeup = 1'h0;
    logic timeout = 1'h0;
    logic [14:0] under_mask = 15'h0000;
    logic [14:0] over_mask = 15'h0000;
    logic fail_req = 1'h0;
    logic done;
    logic fail;
    logic [14:0] c_over, c_under, sw, en, o_flag, u_flag;
    logic [59:0] duty;
    logic start, restart, modulating, sleeping;
    int error_cnt = 0;
    int num_checks = 0;
    always #5 clock = ~clock;
    cell_discharge_pwm_monitor #(.CELLS(15), .SLOT_CYCLES(SLOT)) cell_discharge_pwm_monitor_inst (
        .clock(clock), .rst_b(rst_b), .clock_enable(clock_enable),
        .write_config_group_one_cmd(wr_cmd), .enable_write_data(en_data),
        .duty_write(duty_write), .duty_write_data(duty_data),
        .timer_monitor_enable(mon_en), .watchdog_expired(wdt_exp), .wakeup(wakeup),
        .discharge_timeout(timeout), .conversion_done(done), .cell_over(c_over),
        .cell_under(c_under), .redundancy_fail(fail), .discharge_switch(sw),
        .cell_discharge_enable(en), .duty_setting(duty), .over_flag(o_flag),
        .under_flag(u_flag), .conversion_start(start), .discharge_timer_restart(restart),
        .modulating(modulating), .sleeping(sleeping));
    cell_converter_model cell_converter_model_inst (
        .clock(clock), .rst_b(rst_b), .conversion_start(start), .under_mask(under_mask),
        .over_mask(over_mask), .fail_req(fail_req), .conversion_done(done),
        .cell_over(c_over), .cell_under(c_under), .redundancy_fail(fail));
    // ****************************************
    // shared tasks
    // ****************************************
    task tick;
        @(posedge clock);
        #1;
    endtask
    task check(input string what, input logic [63:0] seen, input logic [63:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task wr_en(input logic [14:0] e);
        wr_cmd = 1'h1;
        en_data = e;
        tick;
        wr_cmd = 1'h0;
    endtask
    task wr_duty(input logic [59:0] d);
        duty_write = 1'h1;
        duty_data = d;
        tick;
        duty_write = 1'h0;
    endtask
    task pulse_timeout;
        timeout = 1'h1;
        tick;
        timeout = 1'h0;
        tick;
    endtask
    task wait_start(output int n);
        n = 0;
        do begin
            tick;
            n++;
            if (n > 2 * PER) begin
                error_cnt++;
                give_verdict;
            end
        end while (start !== 1'h1);
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task t_reset;
        check("duty", duty, {15{4'hF}});
        check("enable", en, 15'h0000);
        check("switch", sw, 15'h0000);
        $display("test reset done");
    endtask
    task t_direct;
        wr_en(15'h2A5A);
        check("switch", sw, 15'h2A5A);
        check("restart", restart, 1'h1);
        tick;
        check("restart", restart, 1'h0);
        wr_duty(60'h0);
        check("restart", restart, 1'h0);
        tick;
        check("switch", sw, 15'h2A5A);
        clock_enable = 1'h0;
        wr_en(15'h7FFF);
        tick;
        check("frozen enable", en, 15'h2A5A);
        clock_enable = 1'h1;
        $display("test direct done");
    endtask
    task t_duty;
        logic [59:0] d;
        int cnt [5];
        int r0, r1, dd, st;
        logic p0, p1;
        for (int c = 0; c < 15; c++) d[4*c+:4] = 4'h7;
        d[19:0] = 20'hFF033;
        wr_duty(d);
        wr_en(15'h7FEF);
        wdt_exp = 1'h1;
        tick;
        tick;
        check("modulating", modulating, 1'h1);
        cnt = '{0, 0, 0, 0, 0};
        r0 = -1;
        r1 = -1;
        st = 0;
        p0 = sw[0];
        p1 = sw[1];
        for (int i = 0; i < PER; i++) begin
            tick;
            for (int c = 0; c < 5; c++) cnt[c] += (sw[c] === 1'h1);
            st += (start === 1'h1);
            if (sw[0] === 1'h1 && p0 === 1'h0 && r0 < 0) r0 = i;
            if (sw[1] === 1'h1 && p1 === 1'h0 && r1 < 0) r1 = i;
            p0 = sw[0];
            p1 = sw[1];
        end
        check("start without monitor", st, 0);
        check("on count duty 3", cnt[0], 3 * STEP);
        check("on count period", cnt[1], 3 * STEP);
        check("on count duty 0", cnt[2], 0);
        check("on count duty F", cnt[3], PER);
        check("on count disabled", cnt[4], 0);
        dd = (r1 - r0 + PER) % PER;
        check("stagger", (dd == SLOT || dd == PER - SLOT), 1);
        $display("test duty done");
    endtask
    task t_monitor;
        int n;
        under_mask = 15'h0003;
        over_mask = 15'h4000;
        mon_en = 1'h1;
        wait_start(n);
        repeat (8) tick;
        check("under flag", u_flag, 15'h0003);
        check("over flag", o_flag, 15'h4000);
        check("enable", en, 15'h7FEC);
        check("switch", sw & 15'h0003, 15'h0000);
        fail_req = 1'h1;
        wait_start(n);
        check("interval", n + 8, PER);
        repeat (8) tick;
        check("enable", en, 15'h0000);
        check("switch", sw, 15'h0000);
        fail_req = 1'h0;
        mon_en = 1'h0;
        $display("test monitor done");
    endtask
    task t_sleep;
        wr_en(15'h7FFF);
        wr_duty(60'h0);
        pulse_timeout;
        check("sleeping", sleeping, 1'h1);
        check("modulating", modulating, 1'h0);
        check("duty", duty, {15{4'hF}});
        check("switch", sw, 15'h0000);
        wr_en(15'h0F0F);
        tick;
        check("sleeping", sleeping, 1'h0);
        wakeup = 1'h1;
        wdt_exp = 1'h0;
        tick;
        wakeup = 1'h0;
        tick;
        check("modulating", modulating, 1'h0);
        check("switch", sw, 15'h0F0F);
        wr_duty({15{4'h5}});
        pulse_timeout;
        check("enable", en, 15'h0000);
        check("duty", duty, {15{4'hF}});
        check("sleeping", sleeping, 1'h0);
        $display("test sleep done");
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        repeat (4) @(posedge clock);
        #1;
        rst_b = 1'h1;
        tick;
        t_reset;
        t_direct;
        t_duty;
        t_monitor;
        t_sleep;
        give_verdict;
    end
endmodule // cell_discharge_pwm_monitor_tb
